// >>> rtl/ptaae_access_ctrl.sv
// Password entry, table select, gated user memory and alarm-enable masks.
//
// Contract
// - Two four-byte passwords, lower and upper.
// - Entry spans 7Bh-7Eh, most significant first.
// - Entry register powers up all ones.
// - Entry locations always read as zero.
// - Upper level includes all lower-level rights.
// - Reference passwords live in upper-only storage.
// - Table-select register picks visible upper table.
// - Table select loads power-on setting at start.
// - User blocks gated by level and grants.
// - Alarm enables gated by third grant pair.
// - First enable byte: temp, supply, mon1, mon2.
// - Second byte: mon3, mon4; low nibble reserved.
// - Fault interrupt is OR of enabled alarms.
// - Mask bit maps enables to table 01h/05h.
// - Mon3 fast-low flag follows last compare.
module ptaae_access_ctrl
   import ptaae_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [7:0] acc_addr,
   input wire logic acc_wr,
   input wire logic acc_rd,
   input wire logic [7:0] acc_wdata,
   output logic [7:0] acc_rdata,
   output logic acc_rvalid,
   output logic acc_hit,
   output logic acc_denied,
   input wire logic [31:0] lower_password_level,
   input wire logic [31:0] upper_password_level,
   input wire logic [7:0] table_select_poweron_value,
   input wire logic alarm_enables_in_table_05,
   input wire logic rw_grant_block_a,
   input wire logic read_grant_block_a,
   input wire logic rw_grant_block_b,
   input wire logic read_grant_block_b,
   input wire logic rw_grant_alarm_enables,
   input wire logic read_grant_alarm_enables,
   input wire logic [7:0] alarm_status_high,
   input wire logic [3:0] alarm_status_low,
   input wire logic mon3_fast_cmp_valid,
   input wire logic mon3_fast_cmp_below,
   input wire logic transmit_disable,
   output logic mon3_fast_low_alarm,
   output logic transmit_fault_interrupt,
   output ptaae_level_e access_level,
   output logic [7:0] upper_table_select
);
   logic [31:0] password_entry_q;
   ptaae_level_e level_q;
   logic [7:0] tsel_q;
   logic tsel_loaded_q;
   logic [7:0] blk_a_q [PTAAE_BLK_A_DEPTH];
   logic [7:0] blk_b_q [PTAAE_BLK_B_DEPTH];
   logic [7:0] alarm_enable_high_q;
   logic [3:0] alarm_enable_low_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic hit_q;
   logic denied_q;
   logic fast_low_q;
   logic fault_q;

   logic hit_pw;
   logic hit_tsel;
   logic hit_a;
   logic hit_b;
   logic hit_aen;
   logic [7:0] aen_table;
   logic rd_ok_a;
   logic wr_ok_a;
   logic rd_ok_b;
   logic wr_ok_b;
   logic rd_ok_aen;
   logic wr_ok_aen;
   logic [1:0] pw_byte;
   logic [7:0] off_a;
   logic [7:0] off_b;
   logic [7:0] rdata_d;
   logic hit_d;
   logic denied_d;
   logic hit_aen_high;
   logic wr_denied;

   // Address decode of the lower-memory control bytes and the upper tables.
   assign hit_pw = (acc_addr >= PTAAE_PW_FIRST_ADDR) && (acc_addr <= PTAAE_PW_LAST_ADDR);
   assign hit_tsel = (acc_addr == PTAAE_TSEL_ADDR);
   assign hit_a = (tsel_q == PTAAE_TABLE_01) && (acc_addr >= PTAAE_BLK_A_FIRST)
      && (acc_addr <= PTAAE_BLK_A_LAST);
   assign hit_b = (tsel_q == PTAAE_TABLE_01) && (acc_addr >= PTAAE_BLK_B_FIRST)
      && (acc_addr <= PTAAE_BLK_B_LAST);
   // The mask bit moves the enable bytes between two tables; they never show up in both.
   assign aen_table = alarm_enables_in_table_05 ? PTAAE_TABLE_05 : PTAAE_TABLE_01;
   assign hit_aen = (tsel_q == aen_table)
      && ((acc_addr == PTAAE_AEN_HIGH_ADDR) || (acc_addr == PTAAE_AEN_LOW_ADDR));
   assign hit_aen_high = (acc_addr == PTAAE_AEN_HIGH_ADDR);
   // Only the two low bits of the entry offset matter once hit_pw has qualified it.
   assign pw_byte = 2'(acc_addr - PTAAE_PW_FIRST_ADDR);
   // Neither block is larger than 64 bytes, so only the low six offset bits index one.
   assign off_a = acc_addr - PTAAE_BLK_A_FIRST;
   assign off_b = acc_addr - PTAAE_BLK_B_FIRST;

   // One permission check per gated region, each with its own grant pair.
   ptaae_grant_check u_grant_a (
      .level(level_q),
      .rw_grant(rw_grant_block_a),
      .read_grant(read_grant_block_a),
      .rd_ok(rd_ok_a),
      .wr_ok(wr_ok_a)
   );

   ptaae_grant_check u_grant_b (
      .level(level_q),
      .rw_grant(rw_grant_block_b),
      .read_grant(read_grant_block_b),
      .rd_ok(rd_ok_b),
      .wr_ok(wr_ok_b)
   );

   ptaae_grant_check u_grant_aen (
      .level(level_q),
      .rw_grant(rw_grant_alarm_enables),
      .read_grant(read_grant_alarm_enables),
      .rd_ok(rd_ok_aen),
      .wr_ok(wr_ok_aen)
   );

   // A refused write is dropped by the storage but still answered on the port, so a
   // host can tell a lost byte from one that landed.
   assign wr_denied = (hit_a && !wr_ok_a) || (hit_b && !wr_ok_b)
      || (hit_aen && !wr_ok_aen);

   // Each entry byte lands in its own lane; the top byte sits at the lowest address.
   // An entry write is open to anyone; only the compare decides what it unlocks.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         password_entry_q <= PTAAE_PW_RESET;
      end else if (acc_wr && hit_pw) begin
         case (pw_byte)
            PTAAE_PW_BYTE_MSB: password_entry_q[31:24] <= acc_wdata;
            PTAAE_PW_BYTE_2: password_entry_q[23:16] <= acc_wdata;
            PTAAE_PW_BYTE_1: password_entry_q[15:8] <= acc_wdata;
            default: password_entry_q[7:0] <= acc_wdata;
         endcase
      end
   end

   // The entry only changes on a write, so a continuous compare settles one
   // cycle after every write. The references arrive from storage that only the
   // upper level can reach and are never readable through this port.
   // Upper is tried first, so equal references resolve to the higher level.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         level_q <= PTAAE_LVL_NONE;
      end else if (password_entry_q == upper_password_level) begin
         level_q <= PTAAE_LVL_UPPER;
      end else if (password_entry_q == lower_password_level) begin
         level_q <= PTAAE_LVL_LOWER;
      end else begin
         level_q <= PTAAE_LVL_NONE;
      end
   end

   // The power-on table comes from a port, so it is taken on the first edge
   // after reset rather than inside the asynchronous reset branch.
   // Any table number is accepted; a table this block does not own reads as zero.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tsel_q <= PTAAE_TSEL_RESET;
         tsel_loaded_q <= 1'b0;
      end else if (!tsel_loaded_q) begin
         tsel_q <= table_select_poweron_value;
         tsel_loaded_q <= 1'b1;
      end else if (acc_wr && hit_tsel) begin
         tsel_q <= acc_wdata;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < PTAAE_BLK_A_DEPTH; i++) begin
            blk_a_q[i] <= PTAAE_BYTE_ZERO;
         end
      end else if (acc_wr && hit_a && wr_ok_a) begin
         blk_a_q[off_a[5:0]] <= acc_wdata;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < PTAAE_BLK_B_DEPTH; i++) begin
            blk_b_q[i] <= PTAAE_BYTE_ZERO;
         end
      end else if (acc_wr && hit_b && wr_ok_b) begin
         blk_b_q[off_b[5:0]] <= acc_wdata;
      end
   end

   // Reserved low nibble of the second byte is not stored at all.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         alarm_enable_high_q <= PTAAE_BYTE_ZERO;
         alarm_enable_low_q <= '0;
      end else if (acc_wr && hit_aen && wr_ok_aen) begin
         if (hit_aen_high) begin
            alarm_enable_high_q <= acc_wdata;
         end else begin
            alarm_enable_low_q <= acc_wdata[7:PTAAE_AEN_LOW_BITS];
         end
      end
   end

   // Read mux; denied or unowned locations read as zero.
   always_comb begin
      rdata_d = PTAAE_BYTE_ZERO;
      hit_d = 1'b1;
      denied_d = 1'b0;
      if (hit_pw) begin
         rdata_d = PTAAE_BYTE_ZERO;
      end else if (hit_tsel) begin
         rdata_d = tsel_q;
      end else if (hit_a) begin
         if (rd_ok_a) begin
            rdata_d = blk_a_q[off_a[5:0]];
         end else begin
            denied_d = 1'b1;
         end
      end else if (hit_b) begin
         if (rd_ok_b) begin
            rdata_d = blk_b_q[off_b[5:0]];
         end else begin
            denied_d = 1'b1;
         end
      end else if (hit_aen) begin
         if (!rd_ok_aen) begin
            denied_d = 1'b1;
         end else if (hit_aen_high) begin
            rdata_d = alarm_enable_high_q;
         end else begin
            rdata_d = {alarm_enable_low_q, 4'h0} & PTAAE_AEN_LOW_USED;
         end
      end else begin
         hit_d = 1'b0;
      end
   end

   // A write is refused silently by the storage; the port still reports it.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= PTAAE_BYTE_ZERO;
         rvalid_q <= 1'b0;
         hit_q <= 1'b0;
         denied_q <= 1'b0;
      end else begin
         rvalid_q <= acc_rd;
         hit_q <= (acc_rd || acc_wr) && hit_d;
         // Read data stays until the next read, so a slow back end may pick it up late.
         if (acc_rd) begin
            rdata_q <= rdata_d;
         end
         if (acc_wr) begin
            denied_q <= wr_denied;
         end else begin
            denied_q <= acc_rd && denied_d;
         end
      end
   end

   // Only a new comparison moves this flag; a transmit disable leaves it alone.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fast_low_q <= 1'b0;
      end else if (mon3_fast_cmp_valid) begin
         fast_low_q <= mon3_fast_cmp_below;
      end
   end

   // Registered, so the line cannot glitch while status and enables change together.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= (|(alarm_status_high & alarm_enable_high_q))
            || (|(alarm_status_low & alarm_enable_low_q));
      end
   end

   // Every port below comes straight from a flop.
   assign acc_rdata = rdata_q;
   assign acc_rvalid = rvalid_q;
   assign acc_hit = hit_q;
   assign acc_denied = denied_q;
   assign mon3_fast_low_alarm = fast_low_q;
   assign transmit_fault_interrupt = fault_q;
   assign access_level = level_q;
   assign upper_table_select = tsel_q;

   // Kept as an input so the disable path is visible; it must not touch the flag.
   logic unused_txd;
   assign unused_txd = transmit_disable;
endmodule : ptaae_access_ctrl

// >>> rtl/ptaae_pkg.sv
// Constants and types shared by the password, table-select and alarm-enable logic.
package ptaae_pkg;
   localparam logic [7:0] PTAAE_PW_FIRST_ADDR = 8'h7b;
   localparam logic [7:0] PTAAE_PW_LAST_ADDR = 8'h7e;
   localparam logic [7:0] PTAAE_TSEL_ADDR = 8'h7f;
   localparam logic [7:0] PTAAE_BLK_A_FIRST = 8'h80;
   localparam logic [7:0] PTAAE_BLK_A_LAST = 8'hbf;
   localparam logic [7:0] PTAAE_BLK_B_FIRST = 8'hc0;
   localparam logic [7:0] PTAAE_BLK_B_LAST = 8'hf7;
   localparam logic [7:0] PTAAE_AEN_HIGH_ADDR = 8'hf8;
   localparam logic [7:0] PTAAE_AEN_LOW_ADDR = 8'hf9;
   localparam logic [7:0] PTAAE_TABLE_01 = 8'h01;
   localparam logic [7:0] PTAAE_TABLE_05 = 8'h05;
   localparam logic [7:0] PTAAE_BYTE_ZERO = 8'h00;
   localparam logic [7:0] PTAAE_TSEL_RESET = 8'h00;
   localparam logic [7:0] PTAAE_AEN_LOW_USED = 8'hf0;
   localparam logic [31:0] PTAAE_PW_RESET = 32'hffff_ffff;
   localparam logic [1:0] PTAAE_PW_BYTE_MSB = 2'h0;
   localparam logic [1:0] PTAAE_PW_BYTE_2 = 2'h1;
   localparam logic [1:0] PTAAE_PW_BYTE_1 = 2'h2;
   localparam int PTAAE_PW_BYTES = 4;
   localparam int PTAAE_BLK_A_DEPTH = 64;
   localparam int PTAAE_BLK_B_DEPTH = 56;
   localparam int PTAAE_AEN_LOW_BITS = 4;

   // Levels nest, so each step up sets one more bit.
   typedef enum logic [1:0] {
      PTAAE_LVL_NONE = 2'b00,
      PTAAE_LVL_LOWER = 2'b01,
      PTAAE_LVL_UPPER = 2'b11
   } ptaae_level_e;
endpackage : ptaae_pkg

// >>> rtl/ptaae_grant_check.sv
// Read and write permission for one password-gated region.
module ptaae_grant_check
   import ptaae_pkg::*;
(
   input wire ptaae_level_e level,
   input wire logic rw_grant,
   input wire logic read_grant,
   output logic rd_ok,
   output logic wr_ok
);
   logic upper_lvl;
   logic lower_lvl;

   // The upper level carries every lower-level right as well.
   assign upper_lvl = (level == PTAAE_LVL_UPPER);
   assign lower_lvl = (level == PTAAE_LVL_LOWER) || upper_lvl;

   assign rd_ok = upper_lvl || (lower_lvl && (rw_grant || read_grant));
   assign wr_ok = upper_lvl || (lower_lvl && rw_grant);
endmodule : ptaae_grant_check

// >>> dv/ptaae_access_ctrl_sva.sv
// Port assertions for the password, table-select and alarm-enable block.
module ptaae_access_ctrl_sva
   import ptaae_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [7:0] acc_addr,
   input wire logic acc_wr,
   input wire logic acc_rd,
   input wire logic [7:0] acc_wdata,
   input wire logic [7:0] acc_rdata,
   input wire logic acc_rvalid,
   input wire logic acc_hit,
   input wire logic acc_denied,
   input wire logic [7:0] alarm_status_high,
   input wire logic [3:0] alarm_status_low,
   input wire logic mon3_fast_cmp_valid,
   input wire logic mon3_fast_cmp_below,
   input wire logic mon3_fast_low_alarm,
   input wire logic transmit_fault_interrupt,
   input wire ptaae_level_e access_level,
   input wire logic [7:0] upper_table_select
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   property p_pw_rd;
      acc_rd && acc_addr inside {[8'h7b:8'h7e]} |=> acc_rvalid && acc_hit && acc_rdata == 8'h00;
   endproperty
   a_pw_rd: assert property (p_pw_rd) else $error("entry read not zero");
   property p_tsel; acc_wr && acc_addr == 8'h7f |=> acc_hit && upper_table_select == $past(acc_wdata); endproperty
   a_tsel: assert property (p_tsel) else $error("table select not written");
   property p_level;
      acc_rd && access_level == PTAAE_LVL_UPPER && upper_table_select == 8'h01 && acc_addr inside {[8'h80:8'hf7]}
         |=> acc_hit && !acc_denied;
   endproperty
   a_level: assert property (p_level) else $error("bad access level");
   property p_quiet; alarm_status_high == 8'h00 && alarm_status_low == 4'h0 |=> !transmit_fault_interrupt; endproperty
   a_quiet: assert property (p_quiet) else $error("fault without alarm");
   property p_fset; mon3_fast_cmp_valid |=> mon3_fast_low_alarm == $past(mon3_fast_cmp_below); endproperty
   a_fset: assert property (p_fset) else $error("fast flag not updated");
   property p_fhold; !mon3_fast_cmp_valid |=> $stable(mon3_fast_low_alarm); endproperty
   a_fhold: assert property (p_fhold) else $error("fast flag moved");
   property p_dzero; acc_rvalid && acc_denied |-> acc_rdata == 8'h00; endproperty
   a_dzero: assert property (p_dzero) else $error("denied read leaked data");
   property p_none;
      (acc_rd || acc_wr) && access_level == PTAAE_LVL_NONE && upper_table_select == 8'h01
         && acc_addr inside {[8'h80:8'hf7]} |=> acc_denied;
   endproperty
   a_none: assert property (p_none) else $error("access without password");
   c_denied: cover property (acc_denied);
   c_upper: cover property (access_level == PTAAE_LVL_UPPER);
   c_fault: cover property (transmit_fault_interrupt);
endmodule : ptaae_access_ctrl_sva
bind ptaae_access_ctrl ptaae_access_ctrl_sva ptaae_access_ctrl_sva_inst (.core_clk(core_clk), .nrst(nrst),
   .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
   .acc_rvalid(acc_rvalid), .acc_hit(acc_hit), .acc_denied(acc_denied), .alarm_status_high(alarm_status_high),
   .alarm_status_low(alarm_status_low), .mon3_fast_cmp_valid(mon3_fast_cmp_valid),
   .mon3_fast_cmp_below(mon3_fast_cmp_below), .mon3_fast_low_alarm(mon3_fast_low_alarm),
   .transmit_fault_interrupt(transmit_fault_interrupt), .access_level(access_level),
   .upper_table_select(upper_table_select));

// >>> dv/ptaae_host_model.sv
// Host model issuing single-byte register accesses.
module ptaae_host_model (
   input wire logic core_clk,
   input wire logic [7:0] acc_rdata,
   input wire logic acc_denied,
   output logic [7:0] acc_addr,
   output logic acc_wr,
   output logic acc_rd,
   output logic [7:0] acc_wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {acc_addr, acc_wr, acc_rd, acc_wdata} = '0;
   // Released address and data are inverted, so a stale value never passes for a live one.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
         output logic den);
      @(posedge core_clk);
      acc_wr <= wr;
      acc_rd <= !wr;
      acc_addr <= a;
      acc_wdata <= d;
      @(posedge core_clk);
      acc_wr <= 1'b0;
      acc_rd <= 1'b0;
      acc_addr <= ~a;
      acc_wdata <= ~d;
      #1;
      q = acc_rdata;
      den = acc_denied;
   endtask : xfer
endmodule : ptaae_host_model

// >>> dv/test_ptaae_access_ctrl.sv
// Self-checking bench for the access-control block.
module test_ptaae_access_ctrl
   import ptaae_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [31:0] pw_lo = 32'hffff_ffff;
   logic [31:0] pw_up = 32'h0000_0000;
   logic mask05 = 1'b0;
   logic [5:0] grant = 6'h00;
   logic [11:0] status = 12'h000;
   logic cmp_v = 1'b0;
   logic cmp_b = 1'b0;
   logic txd = 1'b0;
   logic [7:0] pon = 8'h01;
   logic [7:0] acc_addr, acc_wdata, acc_rdata, tsel, q, e, e2;
   logic acc_wr, acc_rd, acc_rvalid, acc_hit, acc_denied, fast_low, fault, den;
   ptaae_level_e level;
   logic [31:0] seed = 32'h0000_1678;
   int fail_count = 0;
   int tests_run = 0;
   ptaae_host_model ptaae_host_model_inst (.core_clk(core_clk), .acc_rdata(acc_rdata), .acc_denied(acc_denied),
      .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata));
   ptaae_access_ctrl ptaae_access_ctrl_inst (.core_clk(core_clk), .nrst(nrst), .acc_addr(acc_addr),
      .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
      .acc_hit(acc_hit), .acc_denied(acc_denied), .lower_password_level(pw_lo), .upper_password_level(pw_up),
      .table_select_poweron_value(pon), .alarm_enables_in_table_05(mask05), .rw_grant_block_a(grant[5]),
      .read_grant_block_a(grant[4]), .rw_grant_block_b(grant[3]), .read_grant_block_b(grant[2]),
      .rw_grant_alarm_enables(grant[1]), .read_grant_alarm_enables(grant[0]), .alarm_status_high(status[11:4]),
      .alarm_status_low(status[3:0]), .mon3_fast_cmp_valid(cmp_v), .mon3_fast_cmp_below(cmp_b),
      .transmit_disable(txd), .mon3_fast_low_alarm(fast_low), .transmit_fault_interrupt(fault),
      .access_level(level), .upper_table_select(tsel));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Nested levels: the upper level needs no grant, the lower one needs the pair.
   function automatic logic may_write(input ptaae_level_e lv, input logic rw);
      return lv == PTAAE_LVL_UPPER || (lv == PTAAE_LVL_LOWER && rw);
   endfunction : may_write
   function automatic logic may_read(input ptaae_level_e lv, input logic [1:0] gr);
      return lv == PTAAE_LVL_UPPER || (lv == PTAAE_LVL_LOWER && gr != 2'h0);
   endfunction : may_read
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      ptaae_host_model_inst.xfer(wr, a, d, q, den);
   endtask : acc
   task automatic enter(input logic [31:0] pw);
      for (int i = 0; i < 4; i++) acc(1'b1, 8'h7b + 8'(i), pw[31 - 8 * i -: 8]);
      @(posedge core_clk);
      #1;
   endtask : enter
   // Walks the four settings of one grant pair over one region address at a known level, tracking what a permitted write left behind.
   task automatic region(input logic [7:0] a, input int g, input ptaae_level_e lv);
      logic [7:0] mem;
      mem = 8'h00;
      for (int j = 0; j < 4; j++) begin
         grant[g +: 2] <= 2'(j);
         seed = lfsr(seed);
         acc(1'b1, a, seed[7:0]);
         check(den, !may_write(lv, j[1]));
         if (may_write(lv, j[1])) mem = seed[7:0];
         acc(1'b0, a, 8'h00);
         check({den, q}, may_read(lv, j[1:0]) ? {1'b0, mem} : 9'h100);
         check({acc_rvalid, acc_hit}, 2'h3);
      end
   endtask : region
   initial forever #5 core_clk = ~core_clk;
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      stop_test();
   end
   initial begin
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      check(tsel, 8'h01);
      check(level, PTAAE_LVL_LOWER);
      check({fast_low, fault}, 2'h0);
      seed = lfsr(seed);
      pw_lo <= seed;
      seed = lfsr(seed);
      pw_up <= seed;
      @(posedge core_clk);
      #1;
      check(level, PTAAE_LVL_NONE);
      region(8'h80, 4, PTAAE_LVL_NONE);
      enter(pw_lo);
      check(level, PTAAE_LVL_LOWER);
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, 8'h7b + 8'(i), 8'h00);
         check({den, q}, 9'h000);
      end
      region(8'h80, 4, PTAAE_LVL_LOWER);
      region(8'hf7, 2, PTAAE_LVL_LOWER);
      region(8'hf8, 0, PTAAE_LVL_LOWER);
      grant <= 6'h00;
      enter(pw_up);
      check(level, PTAAE_LVL_UPPER);
      region(8'hbf, 4, PTAAE_LVL_UPPER);
      region(8'hc0, 2, PTAAE_LVL_UPPER);
      seed = lfsr(seed);
      e = seed[7:0];
      e2 = seed[15:8];
      acc(1'b1, 8'hf8, e);
      acc(1'b1, 8'hf9, e2);
      acc(1'b0, 8'hf9, 8'h00);
      check(q, e2 & 8'hf0);
      for (int k = 0; k < 12; k++) begin
         seed = lfsr(seed);
         status <= seed[11:0] & seed[23:12];
         @(posedge core_clk);
         #1;
         check(fault, |(status & {e, e2[7:4]}));
      end
      cmp_b <= 1'b1;
      cmp_v <= 1'b1;
      @(posedge core_clk);
      cmp_v <= 1'b0;
      txd <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      check(fast_low, 1'b1);
      cmp_b <= 1'b0;
      cmp_v <= 1'b1;
      @(posedge core_clk);
      cmp_v <= 1'b0;
      @(posedge core_clk);
      #1;
      check(fast_low, 1'b0);
      mask05 <= 1'b1;
      acc(1'b0, 8'hf8, 8'h00);
      check(q, 8'h00);
      acc(1'b1, 8'h7f, 8'h05);
      acc(1'b0, 8'hf8, 8'h00);
      check(q, e);
      acc(1'b0, 8'h7f, 8'h00);
      check(q, 8'h05);
      acc(1'b0, 8'h80, 8'h00);
      check({acc_hit, den, q}, 10'h000);
      // A second reset in mid-run must drop the level and reload the power-on table.
      pon <= 8'h02;
      nrst <= 1'b0;
      @(posedge core_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      check(tsel, 8'h02);
      check(level, PTAAE_LVL_NONE);
      check({fast_low, fault}, 2'h0);
      stop_test();
   end
endmodule : test_ptaae_access_ctrl
